// File: src/odt_lat_if.sv
// carries odt samples to the latency line and the delayed tap back
// assumes the sampling side and the line share core_clk
interface odt_lat_if;
  import odt_pkg::*;
  logic sample;
  logic [LAT_W-1:0] tap_sel;
  logic tapped;
  modport src (output sample, output tap_sel, input tapped);
  modport line (input sample, input tap_sel, output tapped);
endinterface

// File: src/odt_lat_line.sv
// programmable delay line for the sampled odt level
// assumes tap_sel already clamped to 0..DEPTH-1 by the user
module odt_lat_line #(
  parameter int DEPTH = 32
) (
  // clock and reset
  input logic core_clk,
  input logic rst,
  // link to the controller
  odt_lat_if.line lnk
);
  import odt_pkg::*;

  logic [DEPTH-1:0] stage_ff;
  logic [DEPTH-1:0] stage_in;

  // elaboration guard: the tap select field must reach every stage
  if (DEPTH < 2 || DEPTH > (1 << LAT_W))
  begin : g_bad_depth
    $error("odt_lat_line depth out of range");
  end

  // stage inputs: the head takes the new sample, the rest the stage before
  assign stage_in = {stage_ff[DEPTH-2:0], lnk.sample};

  // one flop per clock of latency; stage k is k clocks older than stage 0
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_stage
      always_ff @(posedge core_clk)
      begin
        if (rst)
          stage_ff[gi] <= 1'b0;
        else
          stage_ff[gi] <= stage_in[gi];
      end
    end
  endgenerate

  // variable tap keeps one line serving every latency setting
  assign lnk.tapped = stage_ff[lnk.tap_sel[$clog2(DEPTH)-1:0]];
endmodule

// File: src/odt_pkg.sv
// constants, register map and timing figures of the termination controller
// assumes a single 100 MHz core clock and a synchronous active-high reset
package odt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LAT_W = 6;
  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
  // ctrl fields
  localparam int CWL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam int AL_LSB = 8;
  localparam int NOM_LSB = 10;
  localparam int WRT_LSB = 13;
  localparam int DLLPD_BIT = 15;
  // status fields
  localparam int ST_SYNC = 0;
  localparam int ST_ASYNC = 1;
  localparam int ST_START = 2;
  localparam int ST_FULL = 3;
  localparam int ST_WRSEL = 4;
  localparam int ST_HOLDERR = 5;
  localparam int ST_LAT_LSB = 6;
  // reset values
  localparam logic [3:0] CWL_RST = 4'h5;
  localparam logic [3:0] CL_RST = 4'h6;
  // additive latency field encodings
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL_M1 = 2'h1;
  localparam logic [1:0] AL_CL_M2 = 2'h2;
  // latency and hold figures in clocks
  localparam logic [LAT_W-1:0] LAT_OFFSET = 6'h02;
  localparam logic [LAT_W-1:0] SHORT_HOLD_CYC = 6'h04;
  localparam logic [LAT_W-1:0] LONG_HOLD_CYC = 6'h06;
  // async delays in ns, turned into clocks
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real ASYNC_DLY_MIN_NS = 2.0;
  localparam real ASYNC_DLY_MAX_NS = 8.5;
  localparam int ASYNC_MIN_RAW = int'($ceil(ASYNC_DLY_MIN_NS / CLK_PERIOD_NS));
  localparam int ASYNC_MAX_RAW = int'($floor(ASYNC_DLY_MAX_NS / CLK_PERIOD_NS));
  localparam int ASYNC_MIN_CYC = (ASYNC_MIN_RAW < 1) ? 1 : ASYNC_MIN_RAW;
  localparam int ASYNC_MAX_CYC = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;
endpackage

// File: src/odt_term_ctrl.sv
// on-die termination controller: sync and async regimes, dynamic write select
// assumes odt and commands are synchronous to core_clk, registers on a plain port
//
// Implementation choices: the register addresses and strobed register access.
module odt_term_ctrl #(
  parameter int LINE_DEPTH = 32
) (
  // clock and reset
  input logic core_clk,
  input logic rst,
  // register port
  input logic [odt_pkg::ADDR_W-1:0] reg_addr,
  input logic [odt_pkg::DATA_W-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [odt_pkg::DATA_W-1:0] reg_rdata,
  // controller-side pins and device state
  input logic odt,
  input logic cke,
  input logic cmd_write,
  input logic write_bc4,
  input logic all_banks_idle,
  input logic dll_locked,
  input logic dll_relock,
  // termination state
  output logic term_start,
  output logic term_full,
  output logic write_strength_sel,
  output logic sync_mode,
  output logic async_mode
);
  import odt_pkg::*;

  // elaboration guards: one-clock async model, line depth inside the latency field
  if (ASYNC_MIN_CYC != 1 || ASYNC_MAX_CYC != 1)
  begin : g_bad_async
    $error("async path is built for a one-clock delay");
  end
  if (LINE_DEPTH < 2 || LINE_DEPTH >= (1 << LAT_W))
  begin : g_bad_depth
    $error("line depth does not fit the latency field");
  end

  odt_lat_if lat_if ();

  logic [3:0] write_cas_latency_ff;
  logic [3:0] cas_latency_ff;
  logic [1:0] additive_latency_field_ff;
  logic [2:0] nominal_termination_ff;
  logic [1:0] write_termination_field_ff;
  logic dll_powerdown_select_ff;
  logic odt_q_ff;
  logic [LAT_W-1:0] hold_cnt_ff;
  logic hold_err_ff;
  logic term_start_ff;
  logic term_full_ff;
  logic wr_sel_ff;
  logic dyn_act_ff;
  logic [LAT_W-1:0] dyn_cnt_ff;
  logic [LAT_W-1:0] dyn_hold_ff;
  logic sync_ff;
  logic async_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [LAT_W-1:0] additive_latency;
  logic [LAT_W-1:0] write_latency;
  logic [LAT_W-1:0] term_latency;
  logic term_enabled;
  logic async_c;
  logic sync_c;
  logic nxt_term_start;
  logic [LAT_W-1:0] nxt_hold_cnt;
  logic [LAT_W-1:0] write_hold;
  logic hold_err_set;
  logic hold_err_clr;
  logic dyn_quiet;

  // software configuration
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      write_cas_latency_ff <= CWL_RST;
      cas_latency_ff <= CL_RST;
      additive_latency_field_ff <= AL_ZERO;
      nominal_termination_ff <= 3'h0;
      write_termination_field_ff <= 2'h0;
      dll_powerdown_select_ff <= 1'b0;
    end
    else if (reg_wr && reg_addr == ADDR_CTRL)
    begin
      write_cas_latency_ff <= reg_wdata[CWL_LSB +: 4];
      cas_latency_ff <= reg_wdata[CL_LSB +: 4];
      additive_latency_field_ff <= reg_wdata[AL_LSB +: 2];
      nominal_termination_ff <= reg_wdata[NOM_LSB +: 3];
      write_termination_field_ff <= reg_wdata[WRT_LSB +: 2];
      dll_powerdown_select_ff <= reg_wdata[DLLPD_BIT];
    end
  end

  // latency arithmetic; reserved additive field reads as zero latency
  always_comb
  begin
    if (additive_latency_field_ff == AL_CL_M1)
      additive_latency = LAT_W'({2'h0, cas_latency_ff} - 6'h01);
    else if (additive_latency_field_ff == AL_CL_M2)
      additive_latency = LAT_W'({2'h0, cas_latency_ff} - 6'h02);
    else
      additive_latency = '0;
    write_latency = LAT_W'({2'h0, write_cas_latency_ff} + additive_latency);
    // clamp keeps the tap inside the line for odd settings
    if (write_latency <= LAT_OFFSET)
      term_latency = 6'h01;
    else if (write_latency - LAT_OFFSET >= LAT_W'(LINE_DEPTH))
      term_latency = LAT_W'(LINE_DEPTH - 1);
    else
      term_latency = write_latency - LAT_OFFSET;
  end

  // regime selection
  always_comb
  begin
    term_enabled = (nominal_termination_ff != 3'h0) || (write_termination_field_ff != 2'h0);
    async_c = term_enabled && (dll_relock
      || (!cke && all_banks_idle && !dll_powerdown_select_ff));
    sync_c = term_enabled && dll_locked && !async_c;
  end

  // sampled odt goes into the latency line every rising edge
  assign lat_if.sample = odt;
  assign lat_if.tap_sel = term_latency - 6'h01;

  odt_lat_line #(
    .DEPTH(LINE_DEPTH)
  ) u_line (
    .core_clk(core_clk),
    .rst(rst),
    .lnk(lat_if)
  );

  // next termination level; async path skips the latency line
  always_comb
  begin
    if (!term_enabled)
      nxt_term_start = 1'b0;
    else if (async_c)
      nxt_term_start = odt;
    else if (sync_c)
      nxt_term_start = lat_if.tapped;
    else
      nxt_term_start = 1'b0;
  end

  // termination output; full one clock after start in sync, with start in async, both drop together
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      term_start_ff <= 1'b0;
      term_full_ff <= 1'b0;
    end
    else
    begin
      term_start_ff <= nxt_term_start;
      if (async_c)
        term_full_ff <= nxt_term_start;
      else
        term_full_ff <= term_start_ff && nxt_term_start;
    end
  end

  // regime flags for software and pins
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync_ff <= 1'b0;
      async_ff <= 1'b0;
    end
    else
    begin
      sync_ff <= sync_c;
      async_ff <= async_c;
    end
  end

  // hold tracker: remaining clocks odt must stay registered high
  always_comb
  begin
    write_hold = (write_bc4 ? SHORT_HOLD_CYC : LONG_HOLD_CYC) - 6'h01;
    nxt_hold_cnt = (hold_cnt_ff != '0) ? hold_cnt_ff - 6'h01 : '0;
    if (odt && !odt_q_ff && nxt_hold_cnt < SHORT_HOLD_CYC - 6'h01)
      nxt_hold_cnt = SHORT_HOLD_CYC - 6'h01;
    if (odt && cmd_write && nxt_hold_cnt < write_hold)
      nxt_hold_cnt = write_hold;
    hold_err_set = sync_c && !odt && hold_cnt_ff != '0;
    hold_err_clr = reg_wr && reg_addr == ADDR_STAT && reg_wdata[ST_HOLDERR];
  end

  // tracker state; a short pulse only flags, termination still follows odt
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      odt_q_ff <= 1'b0;
      hold_cnt_ff <= '0;
    end
    else
    begin
      odt_q_ff <= odt;
      hold_cnt_ff <= odt ? nxt_hold_cnt : '0;
    end
  end

  // sticky hold error, write one to clear; a new error beats the clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
      hold_err_ff <= 1'b0;
    else if (hold_err_set)
      hold_err_ff <= 1'b1;
    else if (hold_err_clr)
      hold_err_ff <= 1'b0;
  end

  // dynamic write strength window counted from the write
  always_ff @(posedge core_clk)
  begin
    if (rst || write_termination_field_ff == 2'h0)
    begin
      dyn_act_ff <= 1'b0;
      dyn_cnt_ff <= '0;
      dyn_hold_ff <= '0;
      wr_sel_ff <= 1'b0;
    end
    else if (cmd_write)
    begin
      dyn_act_ff <= 1'b1;
      dyn_cnt_ff <= 6'h01;
      dyn_hold_ff <= write_bc4 ? SHORT_HOLD_CYC : LONG_HOLD_CYC;
      if (dyn_act_ff && dyn_cnt_ff == term_latency + dyn_hold_ff)
        wr_sel_ff <= 1'b0;
    end
    else if (dyn_act_ff)
    begin
      dyn_cnt_ff <= dyn_cnt_ff + 6'h01;
      if (dyn_cnt_ff == term_latency)
        wr_sel_ff <= 1'b1;
      else if (dyn_cnt_ff == term_latency + dyn_hold_ff)
      begin
        wr_sel_ff <= 1'b0;
        dyn_act_ff <= 1'b0;
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_ff <= '0;
    else if (reg_rd && reg_addr == ADDR_CTRL)
      rdata_ff <= DATA_W'({dll_powerdown_select_ff, write_termination_field_ff,
        nominal_termination_ff, additive_latency_field_ff, cas_latency_ff,
        write_cas_latency_ff});
    else if (reg_rd && reg_addr == ADDR_STAT)
      rdata_ff <= DATA_W'({term_latency, hold_err_ff, wr_sel_ff, term_full_ff,
        term_start_ff, async_ff, sync_ff});
    else
      rdata_ff <= '0;
  end

  assign reg_rdata = rdata_ff;
  assign term_start = term_start_ff;
  assign term_full = term_full_ff;
  assign write_strength_sel = wr_sel_ff;
  assign sync_mode = sync_ff;
  assign async_mode = async_ff;

  // quiet window after a write at the shortest latency, watched by the dynamic checks
  assign dyn_quiet = !cmd_write && write_termination_field_ff != 2'h0 && term_latency == 6'h03;

  // checks
  chk_off_hiz: assert property (@(posedge core_clk) disable iff (rst)
    !term_enabled |=> !term_start_ff && !term_full_ff)
    else $error("termination active while disabled");

  chk_async_follow: assert property (@(posedge core_clk) disable iff (rst)
    async_c |=> term_start_ff == $past(odt) && term_full_ff == $past(odt))
    else $error("async termination did not follow odt in one clock");

  chk_sync_on_lat: assert property (@(posedge core_clk) disable iff (rst)
    odt ##3 (sync_c && term_latency == 6'h03) |=> term_start_ff)
    else $error("sync turn-on latency wrong");

  chk_sync_off_lat: assert property (@(posedge core_clk) disable iff (rst)
    !odt ##3 (sync_c && term_latency == 6'h03) |=> !term_start_ff && !term_full_ff)
    else $error("sync turn-off latency wrong");

  chk_full_skew: assert property (@(posedge core_clk) disable iff (rst)
    $rose(term_start_ff) && sync_c |=> term_full_ff || !term_start_ff)
    else $error("termination not fully on one clock after start");

  chk_full_start: assert property (@(posedge core_clk) disable iff (rst)
    term_full_ff |-> term_start_ff)
    else $error("full termination without start");

  chk_short_hold: assert property (@(posedge core_clk) disable iff (rst)
    (odt && !odt_q_ff) ##1 (!odt && sync_c) |=> hold_err_ff)
    else $error("short odt pulse not flagged");

  chk_write_hold: assert property (@(posedge core_clk) disable iff (rst)
    (odt && cmd_write && !write_bc4) ##1 odt [*4] ##1 (!odt && sync_c) |=> hold_err_ff)
    else $error("write hold breach not flagged");

  chk_dyn_off: assert property (@(posedge core_clk) disable iff (rst)
    write_termination_field_ff == 2'h0 |=> !wr_sel_ff)
    else $error("write strength selected with field off");

  chk_unmapped_rd: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr != ADDR_CTRL && reg_addr != ADDR_STAT |=> reg_rdata == '0)
    else $error("unmapped read not zero");

  chk_dyn_on_lat: assert property (@(posedge core_clk) disable iff (rst)
    (cmd_write && write_termination_field_ff != 2'h0 && term_latency == 6'h03)
      ##1 dyn_quiet [*3] |=> wr_sel_ff)
    else $error("write strength not selected one latency after write");

  chk_dyn_off_lat: assert property (@(posedge core_clk) disable iff (rst)
    (cmd_write && write_bc4 && write_termination_field_ff != 2'h0 && term_latency == 6'h03)
      ##1 dyn_quiet [*7] |=> !wr_sel_ff)
    else $error("write strength not released after chop window");

  chk_hold_exact: assert property (@(posedge core_clk) disable iff (rst)
    (odt && !odt_q_ff && !cmd_write) ##1 (odt && !cmd_write) [*3]
      ##1 (!odt && sync_c && !hold_err_ff) |=> !hold_err_ff)
    else $error("exact short hold flagged as error");

  chk_write_ok: assert property (@(posedge core_clk) disable iff (rst)
    (odt && cmd_write && !write_bc4) ##1 (odt && !cmd_write) [*5]
      ##1 (!odt && sync_c && !hold_err_ff) |=> !hold_err_ff)
    else $error("exact long write hold flagged as error");

  chk_err_sticky: assert property (@(posedge core_clk) disable iff (rst)
    hold_err_ff && !hold_err_clr |=> hold_err_ff)
    else $error("hold error lost without a clear");

  chk_rd_idle_zero: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data present without a read");

  chk_wr_sel_field: assert property (@(posedge core_clk) disable iff (rst)
    wr_sel_ff |-> $past(write_termination_field_ff) != 2'h0)
    else $error("write strength selected after field cleared");

  chk_lat_range: assert property (@(posedge core_clk) disable iff (rst)
    term_latency != '0 && term_latency < LAT_W'(LINE_DEPTH))
    else $error("termination latency outside the line");
endmodule

// File: verification/odt_ctrl_model.sv
// controller-side model: drives odt, write commands and burst type
// assumes core_clk shared with the device and start pulses one cycle long
module odt_ctrl_model (
  // clock and reset
  input logic core_clk,
  input logic rst,
  // request from the bench
  input logic start,
  input logic [3:0] hi_cyc,
  input logic with_wr,
  input logic bc4,
  input logic brk,
  // pins toward the device
  output logic odt,
  output logic cmd_write,
  output logic write_bc4
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left_ff;
  logic [3:0] need;
  // shortest high time; brk breaks it on purpose to provoke the hold flag
  always_comb
  begin
    need = 4'h4;
    if (with_wr && !bc4)
      need = 4'h6;
    if (brk || hi_cyc > need)
      need = hi_cyc;
  end
  // odt high for need sampling edges, write rides on the first of them
  // odt stays low between bursts, leaving room for reads there
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      odt <= 1'b0;
      left_ff <= 4'h0;
      write_bc4 <= 1'b0;
      cmd_write <= 1'b0;
    end
    else if (start && left_ff == 4'h0)
    begin
      odt <= 1'b1;
      left_ff <= need;
      cmd_write <= with_wr;
      write_bc4 <= bc4;
    end
    else
    begin
      cmd_write <= 1'b0;
      if (left_ff != 4'h0)
      begin
        left_ff <= left_ff - 4'h1;
        odt <= (left_ff != 4'h1);
      end
    end
  end
endmodule

// File: verification/tb_odt_term_ctrl.sv
// self-checking bench for the termination controller beside a controller model
// assumes odt_pkg, the design and odt_ctrl_model are compiled before it
module tb_odt_term_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import odt_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, cke, all_banks_idle, dll_locked, dll_relock;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic odt, cmd_write, write_bc4, start, with_wr, bc4, brk;
  logic [3:0] hi_cyc;
  logic term_start, term_full, write_strength_sel, sync_mode, async_mode;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_rise [4];
  int t_fall [4];
  logic [3:0] prev = 4'h0;
  wire [3:0] cur = {write_strength_sel, term_full, term_start, odt};
  // {cke, idle, relock, locked, dll kept, sync, async}
  logic [6:0] mode_tab [5] = '{7'h29, 7'h59, 7'h0a, 7'h2e, 7'h40};

  odt_term_ctrl #(.LINE_DEPTH(32)) u_odt_term_ctrl (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .odt(odt), .cke(cke), .cmd_write(cmd_write),
    .write_bc4(write_bc4), .all_banks_idle(all_banks_idle), .dll_locked(dll_locked),
    .dll_relock(dll_relock), .term_start(term_start), .term_full(term_full),
    .write_strength_sel(write_strength_sel), .sync_mode(sync_mode), .async_mode(async_mode));
  odt_ctrl_model u_odt_ctrl_model (.core_clk(core_clk), .rst(rst), .start(start),
    .hi_cyc(hi_cyc), .with_wr(with_wr), .bc4(bc4), .brk(brk), .odt(odt),
    .cmd_write(cmd_write), .write_bc4(write_bc4));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // edge stamps: a change made at edge e is first seen at edge e+1
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    prev <= cur;
    for (int i = 0; i < 4; i++)
    begin
      if (cur[i] === 1'b1 && prev[i] === 1'b0)
        t_rise[i] <= cyc;
      if (cur[i] === 1'b0 && prev[i] === 1'b1)
        t_fall[i] <= cyc;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [31:0] ctrl(int write_cas_latency, int cl, int alc, int nom, int wrt, int kp);
    return (write_cas_latency << CWL_LSB) | (cl << CL_LSB) | (alc << AL_LSB) | (nom << NOM_LSB)
      | (wrt << WRT_LSB) | (kp << DLLPD_BIT);
  endfunction
  function automatic int lat(int write_cas_latency, int cl, int alc);
    return write_cas_latency - 2 + ((alc == 1) ? cl - 1 : (alc == 2) ? cl - 2 : 0);
  endfunction
  // one odt burst, then long enough for the slowest latency to play out
  task automatic burst(input int hi, input logic w, input logic b4, input logic bk);
    t_rise = '{default: 0};
    t_fall = '{default: 0};
    @(posedge core_clk);
    start <= 1'b1;
    hi_cyc <= hi[3:0];
    with_wr <= w;
    bc4 <= b4;
    brk <= bk;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (60) @(posedge core_clk);
  endtask
  // one hold scenario: burst, look at the sticky flag, then clear it
  task automatic hold_case(input int hi, input logic w, input logic b4, input logic bk,
    input logic exp_err);
    logic [31:0] rv;
    burst(hi, w, b4, bk);
    reg_read(ADDR_STAT, rv);
    check(rv[ST_HOLDERR], exp_err);
    reg_write(ADDR_STAT, DATA_W'(1) << ST_HOLDERR);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // the run takes about 1250 cycles; this only trips on a hang
  initial
  begin
    #(20000 * 10);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    int seed, write_cas_latency, cl, l, wbc;
    logic [31:0] rv;
    {rst, reg_wr, reg_rd, start, with_wr, bc4, brk, all_banks_idle, dll_relock} = 9'h100;
    {cke, dll_locked, hi_cyc, reg_addr, reg_wdata} = '0;
    seed = $urandom(53);
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    cke <= 1'b1;
    dll_locked <= 1'b1;
    check({term_start, term_full, write_strength_sel}, 0);
    reg_read(ADDR_CTRL, rv);
    check(rv, ctrl(5, 6, 0, 0, 0, 0));
    reg_write(8'h08, 32'hffff_ffff);
    reg_read(8'h08, rv);
    check(rv, 0);
    reg_read(ADDR_CTRL, rv);
    check(rv, ctrl(5, 6, 0, 0, 0, 0));
    burst(5, 1'b1, 1'b0, 1'b0);
    check(t_rise[1], 0);
    $display("reset and disabled test done");
    for (int k = 0; k < 8; k++)
    begin
      write_cas_latency = 5 + $urandom_range(3);
      cl = 5 + $urandom_range(6);
      wbc = $urandom_range(1);
      l = lat(write_cas_latency, cl, k % 4);
      reg_write(ADDR_CTRL, ctrl(write_cas_latency, cl, k % 4, 1 + $urandom_range(2), k % 3, 0));
      burst(1 + $urandom_range(9), 1'b1, wbc[0], 1'b0);
      check(t_rise[1] - t_rise[0], l + 1);
      check(t_rise[2] - t_rise[1], 1);
      check(t_fall[1] - t_fall[0], l + 1);
      check(t_fall[2] - t_fall[0], l + 1);
      check(t_rise[3] - t_rise[0], (k % 3 == 0) ? -t_rise[0] : l + 1);
      check(t_fall[3] - t_rise[0], (k % 3 == 0) ? -t_rise[0] : l + 5 + 2 * (1 - wbc));
      check(sync_mode, 1);
    end
    $display("sync latency test done");
    for (int k = 0; k < 5; k++)
    begin
      {cke, all_banks_idle, dll_relock, dll_locked} <= mode_tab[k][6:3];
      reg_write(ADDR_CTRL, ctrl(5, 6, 1, 1, 0, mode_tab[k][2]));
      burst(4, 1'b0, 1'b0, 1'b0);
      check({sync_mode, async_mode}, mode_tab[k][1:0]);
      if (mode_tab[k][0])
      begin
        check(t_rise[1] - t_rise[0], 1);
        check(t_rise[2] - t_rise[0], 1);
        check(t_fall[1] - t_fall[0], 1);
        check(t_fall[2] - t_fall[0], 1);
      end
      else if (mode_tab[k][1])
        check(t_rise[1] - t_rise[0], 9);
      else
        check(t_rise[1], 0);
    end
    $display("regime test done");
    {cke, all_banks_idle, dll_relock, dll_locked} <= 4'h9;
    reg_write(ADDR_CTRL, ctrl(5, 6, 0, 1, 1, 0));
    burst(6, 1'b1, 1'b0, 1'b0);
    reg_read(ADDR_STAT, rv);
    check({rv[11:6], rv[ST_HOLDERR], rv[ST_SYNC]}, {6'h03, 2'b01});
    burst(2, 1'b1, 1'b0, 1'b1);
    reg_read(ADDR_STAT, rv);
    check(rv[ST_HOLDERR], 1);
    reg_write(ADDR_STAT, 32'h0000_0020);
    reg_read(ADDR_STAT, rv);
    check(rv[ST_HOLDERR], 0);
    hold_case(4, 1'b1, 1'b1, 1'b0, 1'b0);
    hold_case(1, 1'b0, 1'b0, 1'b1, 1'b1);
    hold_case(5, 1'b1, 1'b0, 1'b1, 1'b1);
    $display("hold test done");
    wrap_up();
  end
endmodule
